/* csf_top.v */
// Purpose: AHB-Lite slave around the status flag register
// Assumes: single word transfers, always OKAY, zero wait states
// Notes: events raise sticky interrupt bits cleared by reading them
`timescale 1ns/1ns
`default_nettype none
`include "csf_regs.vh"
module csf_top (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Flags and bank decode
    output reg [7:0] cpu_status_flags,
    output reg [1:0] direct_bank_q,
    output reg indirect_bank_q,
    // Interrupt
    output reg irq
);
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_mask_q;
    reg op_valid_q;
    reg [3:0] op_code_q;
    reg [7:0] op_a_q;
    reg [7:0] op_b_q;
    reg op_flags_q;
    reg [31:0] rdata_d;
    reg [3:0] stat_clr;
    wire [7:0] flags;
    wire [7:0] result;
    wire wdto_evt;
    wire sleep_evt;
    wire take;
    wire [3:0] evt;
    wire rd_stat;
    reg zero_evt_q;
    reg carry_evt_q;
    assign take = hsel && hready && htrans[1];
    assign rd_stat = take && !hwrite &&
        haddr[7:0] == `CSF_ADDR_IRQ_STAT;
    csf_core u_core (
        .sys_clk(sys_clk),
        .reset(reset),
        .op_valid(op_valid_q),
        .op_code(op_code_q),
        .op_a(op_a_q),
        .op_b(op_b_q),
        .op_to_flags(op_flags_q),
        .flags_q(flags),
        .result_q(result),
        .wdto_evt_q(wdto_evt),
        .sleep_evt_q(sleep_evt)
    );
    assign evt = {carry_evt_q, zero_evt_q, sleep_evt, wdto_evt};
    always @*
    begin
        case (haddr[7:0])
            `CSF_ADDR_FLAGS: rdata_d = {24'h000000, flags};
            `CSF_ADDR_EXEC: rdata_d = {12'h000, op_code_q, op_a_q, op_b_q};
            `CSF_ADDR_RESULT: rdata_d = {24'h000000, result};
            `CSF_ADDR_IRQ_STAT: rdata_d = {28'h0000000, irq_stat_q};
            `CSF_ADDR_IRQ_MASK: rdata_d = {28'h0000000, irq_mask_q};
            `CSF_ADDR_BANK: rdata_d = {29'h0, flags[7:5]};
            default: rdata_d = 32'h00000000;
        endcase
        stat_clr = rd_stat ? irq_stat_q : 4'h0;
    end
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            irq_stat_q <= 4'h0;
            irq_mask_q <= 4'h0;
            op_valid_q <= 1'b0;
            op_code_q <= `CSF_OP_NONE;
            op_a_q <= 8'h00;
            op_b_q <= 8'h00;
            op_flags_q <= 1'b0;
            zero_evt_q <= 1'b0;
            carry_evt_q <= 1'b0;
            cpu_status_flags <= `CSF_FLAGS_RST;
            direct_bank_q <= 2'b00;
            indirect_bank_q <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            wr_pend_q <= take && hwrite;
            if (take)
                wr_addr_q <= haddr[7:0];
            if (take && !hwrite)
                hrdata <= rdata_d;
            op_valid_q <= 1'b0;
            if (wr_pend_q)
            begin
                case (wr_addr_q)
                    `CSF_ADDR_EXEC:
                    begin
                        op_valid_q <= 1'b1;
                        op_code_q <= hwdata[19:16];
                        op_a_q <= hwdata[15:8];
                        op_b_q <= hwdata[7:0];
                        op_flags_q <= hwdata[24];
                    end
                    `CSF_ADDR_IRQ_MASK: irq_mask_q <= hwdata[3:0];
                    default: op_valid_q <= 1'b0;
                endcase
            end
            zero_evt_q <= op_valid_q && (op_code_q == `CSF_OP_ADD ||
                op_code_q == `CSF_OP_SUB) && op_a_q == op_b_q &&
                op_code_q == `CSF_OP_SUB;
            carry_evt_q <= 1'b0;
            // Set wins over the read clear
            irq_stat_q <= (irq_stat_q & ~stat_clr) | evt;
            irq <= |(((irq_stat_q & ~stat_clr) | evt) & irq_mask_q);
            cpu_status_flags <= flags;
            // RQ2 direct bank number
            direct_bank_q <= flags[6:5];
            // RQ1 indirect half
            indirect_bank_q <= flags[7];
        end
    end
endmodule // csf_top
`default_nettype wire

/* csf_regs.vh */
// Purpose: constants for the processor status flag register block
// Assumes: AHB-Lite word registers, one byte of flags in the low bits
// Notes: included by the bus slave and the flag core
//
// Function
// RQ1 - Indirect bank select: 1 picks banks 2-3, 0 picks banks 0-1.
// RQ2 - Two direct bank bits decode to bank 0..3, 128 bytes each.
// RQ3 - Watchdog-expired flag set at power-up, watchdog clear and sleep.
// RQ4 - Watchdog-expired flag cleared when the watchdog times out.
// RQ5 - Sleep-entered flag set at power-up and on watchdog clear.
// RQ6 - Sleep-entered flag cleared when sleep executes.
// RQ7 - Zero flag set on all-zero result, cleared otherwise.
// RQ8 - Nibble carry flag follows carry out of bit 3 for add/sub.
// RQ9 - Carry flag follows carry out of the top bit for add/sub.
// RQ10 - For subtraction the carry flags mean no borrow when 1.
// RQ11 - Subtraction adds the two's complement of the second operand.
// RQ12 - Rotates through carry load carry with the bit shifted out.
// RQ13 - Writes to zero, nibble carry, carry ignored when op sets them.
// RQ14 - Software cannot write the watchdog-expired or sleep-entered flags.
// RQ15 - Reset clears bank bits, sets reset-cause flags, arith flags arbitrary.
`ifndef CSF_REGS_VH
`define CSF_REGS_VH
// Byte addresses
`define CSF_ADDR_FLAGS 8'h00
`define CSF_ADDR_EXEC 8'h04
`define CSF_ADDR_RESULT 8'h08
`define CSF_ADDR_IRQ_STAT 8'h0C
`define CSF_ADDR_IRQ_MASK 8'h10
`define CSF_ADDR_BANK 8'h14
// Flag bit positions
`define CSF_BIT_IND 7
`define CSF_BIT_RPH 6
`define CSF_BIT_RPL 5
`define CSF_BIT_WDX 4
`define CSF_BIT_SLP 3
`define CSF_BIT_Z 2
`define CSF_BIT_DC 1
`define CSF_BIT_C 0
// Flag reset value, arithmetic flags chosen as zero
`define CSF_FLAGS_RST 8'h18
// Operation codes in the exec register
`define CSF_OP_NONE 4'h0
`define CSF_OP_ADD 4'h1
`define CSF_OP_SUB 4'h2
`define CSF_OP_AND 4'h3
`define CSF_OP_RRF 4'h4
`define CSF_OP_RLF 4'h5
`define CSF_OP_MOVE 4'h6
`define CSF_OP_WATCHDOG_CLEAR_INSTR 4'h7
`define CSF_OP_SLEEP 4'h8
`define CSF_OP_WDTO 4'h9
`define CSF_OP_CLR 4'hA
// Exec register fields
`define CSF_EX_OP_LSB 16
`define CSF_EX_A_LSB 8
`define CSF_EX_B_LSB 0
// Interrupt status bits
`define CSF_IRQ_WDTO 0
`define CSF_IRQ_SLEEP 1
`define CSF_IRQ_ZERO 2
`define CSF_IRQ_CARRY 3
`endif

/* csf_core.v */
// Purpose: status flag register with ALU flag update
// Assumes: one operation at a time, op_valid a one-cycle pulse
// Notes: all updates land on the edge after op_valid
`timescale 1ns/1ns
`default_nettype none
`include "csf_regs.vh"
module csf_core (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Operation request
    input wire op_valid,
    input wire [3:0] op_code,
    input wire [7:0] op_a,
    input wire [7:0] op_b,
    input wire op_to_flags,
    // State
    output reg [7:0] flags_q,
    output reg [7:0] result_q,
    output reg wdto_evt_q,
    output reg sleep_evt_q
);
    reg [7:0] flags_d;
    reg [7:0] result_d;
    reg [8:0] sum;
    reg [4:0] nib;
    reg [7:0] bop;
    always @*
    begin
        flags_d = flags_q;
        result_d = result_q;
        // RQ11 two's complement subtract
        // Invert plus carry-in, so the +1 reaches both carry chains
        bop = (op_code == `CSF_OP_SUB) ? ~op_b : op_b;
        // RQ10 carry is not-borrow
        sum = {1'b0, op_a} + {1'b0, bop} +
            {8'h00, (op_code == `CSF_OP_SUB)};
        nib = {1'b0, op_a[3:0]} + {1'b0, bop[3:0]} +
            {4'h0, (op_code == `CSF_OP_SUB)};
        if (op_valid)
        begin
            case (op_code)
                `CSF_OP_ADD, `CSF_OP_SUB:
                begin
                    result_d = sum[7:0];
                    // RQ7 zero flag
                    flags_d[`CSF_BIT_Z] = (sum[7:0] == 8'h00);
                    // RQ8 nibble carry
                    flags_d[`CSF_BIT_DC] = nib[4];
                    // RQ9 top carry
                    flags_d[`CSF_BIT_C] = sum[8];
                end
                `CSF_OP_AND:
                begin
                    result_d = op_a & op_b;
                    flags_d[`CSF_BIT_Z] = ((op_a & op_b) == 8'h00);
                end
                `CSF_OP_CLR:
                begin
                    result_d = 8'h00;
                    flags_d[`CSF_BIT_Z] = 1'b1;
                end
                `CSF_OP_RRF:
                begin
                    // RQ12 shifted-out bit
                    result_d = {flags_q[`CSF_BIT_C], op_a[7:1]};
                    flags_d[`CSF_BIT_C] = op_a[0];
                end
                `CSF_OP_RLF:
                begin
                    result_d = {op_a[6:0], flags_q[`CSF_BIT_C]};
                    flags_d[`CSF_BIT_C] = op_a[7];
                end
                `CSF_OP_MOVE:
                begin
                    result_d = op_a;
                end
                `CSF_OP_WATCHDOG_CLEAR_INSTR:
                begin
                    // RQ3 RQ5 set both
                    flags_d[`CSF_BIT_WDX] = 1'b1;
                    flags_d[`CSF_BIT_SLP] = 1'b1;
                end
                `CSF_OP_SLEEP:
                begin
                    // RQ3 RQ6 sleep entry
                    flags_d[`CSF_BIT_WDX] = 1'b1;
                    flags_d[`CSF_BIT_SLP] = 1'b0;
                end
                `CSF_OP_WDTO:
                begin
                    // RQ4 time-out clears
                    flags_d[`CSF_BIT_WDX] = 1'b0;
                end
                default:
                begin
                    result_d = result_q;
                end
            endcase
            if (op_to_flags && op_code != `CSF_OP_WATCHDOG_CLEAR_INSTR &&
                op_code != `CSF_OP_SLEEP && op_code != `CSF_OP_WDTO &&
                op_code != `CSF_OP_NONE)
            begin
                // RQ13 write lands on bank bits for any op but none, watchdog clear, sleep and time-out; on Z, DC, C only for move
                flags_d[7:5] = result_d[7:5];
                if (op_code == `CSF_OP_MOVE)
                    flags_d[2:0] = result_d[2:0];
                // RQ14 reset-cause bits never written
            end
        end
    end
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            // RQ15 reset values
            flags_q <= `CSF_FLAGS_RST;
            result_q <= 8'h00;
            wdto_evt_q <= 1'b0;
            sleep_evt_q <= 1'b0;
        end
        else
        begin
            flags_q <= flags_d;
            result_q <= result_d;
            wdto_evt_q <= op_valid && op_code == `CSF_OP_WDTO;
            sleep_evt_q <= op_valid && op_code == `CSF_OP_SLEEP;
        end
    end
endmodule // csf_core
`default_nettype wire

/* csf_top_sva.sv */
// Purpose: port assertions for the status flag block
// Assumes: one clock, asynchronous active-high reset
// Notes: bound to every csf_top instance below
`timescale 1ns/1ns
`default_nettype none
module csf_top_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hreadyout,
    input wire logic hresp,
    // Flags
    input wire logic [7:0] cpu_status_flags,
    input wire logic [1:0] direct_bank_q,
    input wire logic indirect_bank_q,
    input wire logic irq
);
    wire logic [7:0] f;
    assign f = cpu_status_flags;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    a_bus_okay: assert property (!hresp && hreadyout)
        else $error("bus answer not zero-wait OKAY");
    a_direct_bank: assert property (direct_bank_q == f[6:5])
        else $error("direct bank output differs from flags");
    a_indirect_bank: assert property (indirect_bank_q == f[7])
        else $error("indirect bank output differs from flags");
    a_reset_value: assert property ($fell(reset) |-> f[7:3] == 5'h03)
        else $error("flags wrong after reset");
    // Quiet bus must leave flags alone, software writes included
    a_idle_stable: assert property
        (!(hsel && htrans[1]) [*4] |=> $stable(f))
        else $error("flags moved with no request");
    a_sleep_flags: assert property ($fell(f[3]) |-> f[4])
        else $error("sleep left timeout flag low");
    a_timeout_only: assert property ($fell(f[4]) |-> $stable(f[3]))
        else $error("timeout disturbed sleep flag");
    a_clear_sets: assert property ($rose(f[3]) |-> f[4])
        else $error("sleep flag rose without timeout flag");
    cover property ($fell(f[3]));
    cover property ($fell(f[4]));
    cover property (irq);
    cover property (direct_bank_q == 2'h3);
endmodule // csf_top_sva
bind csf_top csf_top_sva u_sva (.sys_clk, .reset, .hsel, .htrans,
    .hreadyout, .hresp, .cpu_status_flags, .direct_bank_q,
    .indirect_bank_q, .irq);
`default_nettype wire

/* cpu_status_flag_register_tb_top.sv */
// Purpose: self-checking bench for the status flag block
// Assumes: zero-wait slave, flags settle within six cycles of exec
// Notes: a bench model predicts flags, result and interrupts
`timescale 1ns/1ns
`default_nettype none
`include "csf_regs.vh"
module cpu_status_flag_register_tb_top;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hready, hresp, irq, ind_o;
    wire [7:0] flags_o;
    wire [1:0] dbank_o;
    logic [7:0] mf = 8'h18;
    logic [7:0] ms = 8'h0;
    logic [7:0] mm = 8'h0;
    logic [31:0] rd, v = 32'd94021;
    logic [20:0] tbl [15] = '{21'h10F01, 21'h1FF01, 21'h20505, 21'h20305,
        21'h3F00F, 21'h40100, 21'h58000, 21'h16E000, 21'h11A001, 21'h1A0000,
        21'h16FF00, 21'h70000, 21'h80000, 21'h90000, 21'h70000};
    int err_total = 0;
    int checks = 0;
    always #5 sys_clk = ~sys_clk;
    csf_top uut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .cpu_status_flags(flags_o),
        .direct_bank_q(dbank_o), .indirect_bank_q(ind_o), .irq(irq));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
            err_total++;
        end
    endtask
    // Address phase held until hready, then data phase until hready
    task automatic bus(input logic [31:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic exec(input logic [3:0] op, input logic [7:0] a,
        input logic [7:0] b, input logic d);
        logic [7:0] f, r, bb;
        logic [8:0] s;
        logic [4:0] n;
        logic sub, fop;
        bus(`CSF_ADDR_EXEC, 1'b1, {7'h0, d, 4'h0, op, a, b}, rd);
        f = mf;
        sub = (op == `CSF_OP_SUB);
        fop = op inside {[4'h1:4'h5], `CSF_OP_CLR};
        // Subtract adds the two's complement, so carry means no borrow
        bb = sub ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h0, sub};
        n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
        r = (op == `CSF_OP_AND) ? (a & b) : s[7:0];
        r = (op == `CSF_OP_RRF) ? {mf[0], a[7:1]} : r;
        r = (op == `CSF_OP_RLF) ? {a[6:0], mf[0]} : r;
        r = (op == `CSF_OP_CLR) ? 8'h0 : r;
        r = (op == `CSF_OP_MOVE) ? a : r;
        if (op == `CSF_OP_ADD || sub)
            f[1:0] = {n[4], s[8]};
        if (op == `CSF_OP_RRF || op == `CSF_OP_RLF)
            f[0] = (op == `CSF_OP_RRF) ? a[0] : a[7];
        if (op inside {4'h1, 4'h2, 4'h3, `CSF_OP_CLR})
            f[2] = (r == 8'h0);
        if (d && fop)
            f[7:5] = r[7:5];
        if (d && op == `CSF_OP_MOVE)
            {f[7:5], f[2:0]} = {a[7:5], a[2:0]};
        if (op == `CSF_OP_WATCHDOG_CLEAR_INSTR || op == `CSF_OP_SLEEP)
            f[4:3] = {1'b1, op == `CSF_OP_WATCHDOG_CLEAR_INSTR};
        if (op == `CSF_OP_WDTO)
            f[4] = 1'b0;
        ms = ms | {5'h0, sub && a == b, op == `CSF_OP_SLEEP,
            op == `CSF_OP_WDTO};
        mf = f;
        repeat (6) @(posedge sys_clk);
        bus(`CSF_ADDR_FLAGS, 1'b0, 32'h0, rd);
        chk({24'h0, mf}, rd);
        chk({24'h0, mf}, {24'h0, flags_o});
        chk({29'h0, mf[7:5]}, {29'h0, ind_o, dbank_o});
        chk({31'h0, |(ms & mm)}, {31'h0, irq});
        bus(`CSF_ADDR_BANK, 1'b0, 32'h0, rd);
        chk({29'h0, mf[7:5]}, rd);
        bus(`CSF_ADDR_EXEC, 1'b0, 32'h0, rd);
        chk({12'h0, op, a, b}, rd);
        bus(`CSF_ADDR_RESULT, 1'b0, 32'h0, rd);
        if (fop || op == `CSF_OP_MOVE)
            chk({24'h0, r}, rd);
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        bus(`CSF_ADDR_FLAGS, 1'b0, 32'h0, rd);
        chk(32'h18, rd);
        bus(`CSF_ADDR_FLAGS, 1'b1, 32'hFF, rd);
        bus(`CSF_ADDR_FLAGS, 1'b0, 32'h0, rd);
        chk(32'h18, rd);
        bus(32'h40, 1'b0, 32'h0, rd);
        chk(32'h0, rd);
        bus(`CSF_ADDR_IRQ_MASK, 1'b1, 32'h7, rd);
        mm = 8'h7;
        bus(`CSF_ADDR_IRQ_MASK, 1'b0, 32'h0, rd);
        chk(32'h7, rd);
        $display("test reset and access done");
        for (int i = 0; i < 15; i++)
            exec(tbl[i][19:16], tbl[i][15:8], tbl[i][7:0], tbl[i][20]);
        $display("test fixed operations done");
        bus(`CSF_ADDR_IRQ_STAT, 1'b0, 32'h0, rd);
        chk({24'h0, ms}, rd);
        ms = 8'h0;
        repeat (3) @(posedge sys_clk);
        chk(32'h0, {31'h0, irq});
        bus(`CSF_ADDR_IRQ_MASK, 1'b1, 32'h0, rd);
        mm = 8'h0;
        exec(`CSF_OP_SLEEP, 8'h0, 8'h0, 1'b0);
        exec(`CSF_OP_NONE, 8'h55, 8'hAA, 1'b1);
        bus(`CSF_ADDR_IRQ_STAT, 1'b0, 32'h0, rd);
        chk({24'h0, ms}, rd);
        ms = 8'h0;
        $display("test interrupts done");
        for (int i = 0; i < 24; i++)
        begin
            v = xs(v);
            exec(4'h1 + 4'(v[18:16] % 3'h5), v[15:8], v[7:0], v[24]);
        end
        $display("test random operations done");
        wrap_up();
    end
    initial
    begin
        #50000;
        err_total++;
        wrap_up();
    end
endmodule // cpu_status_flag_register_tb_top
`default_nettype wire
